// ### jtag_host.sv
// Host model that drives the test pins of the boundary-scan port.
// Assumes put_bit is entered at a falling clk edge; one bit is 8 clk.
`timescale 1ns/1ps

module jtag_host (
   // Clock
   input wire logic clk,
   // Test pins
   output tap_pkg::jtag_in_t pins,
   output logic tms_driven,
   output logic tdi_driven,
   input tap_pkg::jtag_out_t answer
);
   import tap_pkg::*;

   logic drive_tms = 1'b1;
   logic drive_tdi = 1'b1;
   logic seen_tdo;
   logic seen_oe_n;
   event got;

   // Test clock stands low between bits
   initial begin
      pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      tms_driven = 1'b1;
      tdi_driven = 1'b1;
   end

   // --------------------------------
   // One test-clock period
   // --------------------------------
   // mode sequence selects path
   // Released pins show the inverse of their last level, so a wrong pull-up shows
   task automatic put_bit(input logic tms, input logic tdi);
      tms_driven = drive_tms;
      tdi_driven = drive_tdi;
      pins.tms = drive_tms ? tms : ~pins.tms;
      pins.tdi = drive_tdi ? tdi : ~pins.tdi;
      repeat (4) @(negedge clk);
      pins.tck = 1'b1;
      repeat (4) @(negedge clk);
      // Output is taken just before the fall, where it has stood longest
      seen_tdo = answer.tdo;
      seen_oe_n = answer.tdo_oe_n;
      ->got;
      pins.tck = 1'b0;
   endtask
endmodule

// ### sram_boundary_scan_tap.sv
// Boundary-scan test access port of a burst SRAM.
// Assumes the pins arrive asynchronously and are sampled by clk, which
// runs much faster than the test clock; pin pull-ups are modelled here from the drive flags.
//
// How it works
// R01: Sample mode and data on test-clock rise
// R02: Data out changes on fall, driven only while shifting
// R03: Floating mode-select reads as one
// R04: Floating data input reads as one
// R05: Five high mode-select rises force reset
// R06: Controller resets itself at power-up
// R07: Idle and harmless unless clock toggles
// R08: Three-bit instruction, loaded only when selected
// R09: Reset presets the identification instruction
// R10: Instruction acts in idle and data states
// R11: Shift in on rise, out after fall
// R12: Exactly one register in the path
// R13: Bypass is a single one-bit delay
// R14: Unbonded scan cells always capture one
// R15: Boundary register captures pins, then shifts
// R16: Boundary path only for three instructions
// R17: Decode extest, ident, hiz, sample, bypass
// R18: Instruction capture loads 01 low bits
// R19: Ident is 32 bits, LSB first
// R20: High-impedance sample floats memory outputs
// R21: Private codes act as plain bypass
`timescale 1ns/1ps
`include "tap_defs.svh"

module sram_boundary_scan_tap
   import tap_pkg::*;
#(
   parameter int BSR_WIDTH = 8,
   parameter int PIN_COUNT = 6,
   parameter logic [`ID_WIDTH-1:0] ID_CODE = 32'h0000_0A5B // Arbitrary value
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Test pins, with pull-up enables
   input tap_pkg::jtag_in_t jtag_in,
   input wire logic tms_driven,
   input wire logic tdi_driven,
   output tap_pkg::jtag_out_t jtag_out,
   // Memory pin ring
   input wire logic [PIN_COUNT-1:0] ring_pins,
   output logic mem_out_hiz,
   output logic extest_on,
   output logic [BSR_WIDTH-1:0] bsr_update
);
   import tap_pkg::*;

   // Refused at elaboration: the ring must fit inside the scan chain
   if (PIN_COUNT < 1 || PIN_COUNT > BSR_WIDTH || BSR_WIDTH < 2) begin : g_bad_size
      $error("PIN_COUNT must lie in 1 to BSR_WIDTH, BSR_WIDTH at least 2");
   end

   // ----------------------------------------
   // Pin sampling
   // ----------------------------------------
   logic [2:0] pin_raw;
   logic [2:0] pin_s;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic tck_prev_q;
   logic tck_rise;
   logic tck_fall;
   logic [1:0] settle_q;

   // R03: floating mode-select is one
   // R04: floating data input is one
   assign pin_raw = {jtag_in.tck, jtag_in.tms | ~tms_driven, jtag_in.tdi | ~tdi_driven};

   tap_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .async_in(pin_raw),
      .sync_out(pin_s)
   );

   assign tck_s = pin_s[2];
   assign tms_s = pin_s[1];
   assign tdi_s = pin_s[0];

   // Edge detector on the synchronised test clock
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tck_prev_q <= 1'b1;
      end else begin
         tck_prev_q <= tck_s;
      end
   end

   // Edges count only once the chain holds real pin levels; its reset
   // value would otherwise fake an edge right after reset
   always_ff @(posedge clk) begin
      if (!nrst) begin
         settle_q <= '0;
      end else if (settle_q != 2'h3) begin
         settle_q <= settle_q + 2'h1;
      end
   end

   // R01: sample mode and data only on test-clock rises
   // R07: no test-clock edge, no activity
   assign tck_rise = tck_s & ~tck_prev_q & (settle_q == 2'h3);
   assign tck_fall = ~tck_s & tck_prev_q & (settle_q == 2'h3);

   // ----------------------------------------
   // Controller state machine
   // ----------------------------------------
   tap_state_t state_q;
   tap_state_t state_d;

   // R12: mode-select sequence picks the path
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RESET: state_d = tms_s ? ST_RESET : ST_IDLE;
         ST_IDLE: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_d = tms_s ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: state_d = tms_s ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: state_d = tms_s ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: state_d = tms_s ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_d = tms_s ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: state_d = tms_s ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: state_d = tms_s ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
         default: state_d = ST_RESET;
      endcase
   end

   // R06: power-up reset lands in reset state
   // R05: five high rises reach reset from anywhere
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= ST_RESET;
      end else if (tck_rise) begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // Instruction register
   // ----------------------------------------
   logic [`IR_WIDTH-1:0] ir_shift_q;
   logic [`IR_WIDTH-1:0] ir_q;

   // R08: loads only while in the path
   // R18: capture puts 01 in the low bits
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ir_shift_q <= `IR_IDCODE;
      end else if (tck_rise) begin
         if (state_q == ST_CAP_IR) begin
            ir_shift_q <= {ir_shift_q[`IR_WIDTH-1], `IR_CAPTURE_LOW};
         end else if (state_q == ST_SH_IR) begin
            ir_shift_q <= {tdi_s, ir_shift_q[`IR_WIDTH-1:1]};
         end
      end
   end

   // R09: reset presets ident instruction
   // R10: new instruction held from update on
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ir_q <= `IR_IDCODE;
      end else if (tck_rise && state_q == ST_RESET) begin
         ir_q <= `IR_IDCODE;
      end else if (tck_fall && state_q == ST_UPD_IR) begin
         ir_q <= ir_shift_q;
      end
   end

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   logic sel_bsr;
   logic sel_id;

   // R17: code map
   // R16: boundary path for three codes only
   // R21: every other code falls to bypass
   assign sel_bsr = (ir_q == `IR_EXTEST) || (ir_q == `IR_HIZ_SAMPLE) || (ir_q == `IR_SAMPLE);
   assign sel_id = (ir_q == `IR_IDCODE);

   // R20: outputs float under hiz sample
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mem_out_hiz <= 1'b0;
         extest_on <= 1'b0;
      end else begin
         mem_out_hiz <= (ir_q == `IR_HIZ_SAMPLE);
         extest_on <= (ir_q == `IR_EXTEST);
      end
   end

   // ----------------------------------------
   // Data registers
   // ----------------------------------------
   logic cap_dr;
   logic sh_dr;
   logic bypass_q;
   logic [`ID_WIDTH-1:0] id_val;
   logic [BSR_WIDTH-1:0] bsr_val;
   logic [BSR_WIDTH-1:0] bsr_cap;
   logic [PIN_COUNT-1:0] ring_s;

   assign cap_dr = tck_rise && state_q == ST_CAP_DR;
   assign sh_dr = tck_rise && state_q == ST_SH_DR;

   // Memory pins live on their own clock; lanes settle independently, so pins must be still
   tap_sync #(.WIDTH(PIN_COUNT), .RESET_VAL('0)) u_ring_sync (
      .clk(clk),
      .nrst(nrst),
      .async_in(ring_pins),
      .sync_out(ring_s)
   );

   // R14: unbonded cells capture one
   // R15: pins loaded in capture
   genvar gi;
   generate
      for (gi = 0; gi < BSR_WIDTH; gi++) begin : g_cell
         if (gi < PIN_COUNT) begin : g_pin
            assign bsr_cap[gi] = ring_s[gi];
         end else begin : g_fill
            assign bsr_cap[gi] = 1'b1;
         end
      end
   endgenerate

   // R19: 32-bit ident, LSB first
   tap_shift #(.WIDTH(`ID_WIDTH)) u_id (
      .clk(clk),
      .nrst(nrst),
      .capture(cap_dr && sel_id),
      .shift(sh_dr && sel_id),
      .capture_val(ID_CODE),
      .shift_in(tdi_s),
      .value(id_val)
   );

   // R15: boundary register in the path
   tap_shift #(.WIDTH(BSR_WIDTH)) u_bsr (
      .clk(clk),
      .nrst(nrst),
      .capture(cap_dr && sel_bsr),
      .shift(sh_dr && sel_bsr),
      .capture_val(bsr_cap),
      .shift_in(tdi_s),
      .value(bsr_val)
   );

   // R13: single-bit bypass stage
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bypass_q <= 1'b0;
      end else if (cap_dr && !sel_bsr && !sel_id) begin
         bypass_q <= 1'b0;
      end else if (sh_dr && !sel_bsr && !sel_id) begin
         bypass_q <= tdi_s;
      end
   end

   // Update stage loads under any boundary instruction: extest, hiz sample or sample
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bsr_update <= '0;
      end else if (tck_fall && state_q == ST_UPD_DR && sel_bsr) begin
         bsr_update <= bsr_val;
      end
   end

   // ----------------------------------------
   // Serial output
   // ----------------------------------------
   logic tdo_bit;
   logic shifting;

   // R12: one register chosen for the output
   always_comb begin
      if (state_q == ST_SH_IR) begin
         tdo_bit = ir_shift_q[0];
      end else if (sel_bsr) begin
         tdo_bit = bsr_val[0];
      end else if (sel_id) begin
         tdo_bit = id_val[0];
      end else begin
         tdo_bit = bypass_q;
      end
   end

   assign shifting = (state_q == ST_SH_IR) || (state_q == ST_SH_DR);

   // R02: output updates on falls only
   // R11: outgoing bit shown after the fall
   always_ff @(posedge clk) begin
      if (!nrst) begin
         jtag_out.tdo <= 1'b1;
         jtag_out.tdo_oe_n <= 1'b1;
      end else if (tck_fall) begin
         jtag_out.tdo <= tdo_bit;
         jtag_out.tdo_oe_n <= ~shifting;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [2:0] ones_cnt_q;

   // Counts test-clock rises with mode-select high
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ones_cnt_q <= '0;
      end else if (tck_rise) begin
         ones_cnt_q <= tms_s ? ((ones_cnt_q == 3'h7) ? 3'h7 : ones_cnt_q + 3'h1) : 3'h0;
      end
   end

   chk_five_ones_reset: assert property (@(posedge clk) disable iff (!nrst) // R05
      ones_cnt_q >= 3'(`RESET_TMS_ONES) |-> state_q == ST_RESET)
      else $error("five high rises did not reach reset");

   chk_state_on_rise: assert property (@(posedge clk) disable iff (!nrst) // R01
      !tck_rise |=> $stable(state_q))
      else $error("state moved without a test-clock rise");

   chk_tdo_on_fall: assert property (@(posedge clk) disable iff (!nrst) // R02
      !$past(tck_fall) |-> $stable(jtag_out.tdo))
      else $error("serial output moved without a fall");

   chk_tdo_idle_off: assert property (@(posedge clk) disable iff (!nrst) // R02
      $past(tck_fall) && !$past(shifting) |-> jtag_out.tdo_oe_n)
      else $error("serial output driven outside shifting");

   chk_ir_reset_id: assert property (@(posedge clk) disable iff (!nrst) // R09
      tck_rise && state_q == ST_RESET |=> ir_q == `IR_IDCODE)
      else $error("reset did not preset ident instruction");

   chk_ir_capture: assert property (@(posedge clk) disable iff (!nrst) // R18
      tck_rise && state_q == ST_CAP_IR |=> ir_shift_q[1:0] == `IR_CAPTURE_LOW)
      else $error("instruction capture pattern wrong");

   chk_hiz_follows: assert property (@(posedge clk) disable iff (!nrst) // R20
      ir_q == `IR_HIZ_SAMPLE ##1 ir_q == `IR_HIZ_SAMPLE |-> mem_out_hiz)
      else $error("hiz sample did not float outputs");

   chk_bypass_delay: assert property (@(posedge clk) disable iff (!nrst) // R13
      sh_dr && !sel_bsr && !sel_id |=> bypass_q == $past(tdi_s))
      else $error("bypass did not take the input bit");

   chk_bsr_fill_one: assert property (@(posedge clk) disable iff (!nrst) // R14
      (PIN_COUNT < BSR_WIDTH) && cap_dr && sel_bsr |=> bsr_val[BSR_WIDTH-1])
      else $error("unbonded cell did not capture one");
endmodule

// ### tap_defs.svh
// Constants of the boundary-scan test access port.
// Assumes inclusion by the package and the design modules only.
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define IR_WIDTH 3
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_HIZ_SAMPLE 3'h2
`define IR_SAMPLE 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE_LOW 2'h1

// ----------------------------------------
// Register widths and defaults
// ----------------------------------------
`define ID_WIDTH 32
`define RESET_TMS_ONES 5
`define SYNC_STAGES 2

`endif

// ### tap_pkg.sv
// Types of the boundary-scan test access port.
// Assumes tap_defs.svh is reachable by bare name.
`include "tap_defs.svh"

package tap_pkg;

   // ----------------------------------------
   // Controller states and pin groups
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
      ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR,
      ST_EX2_IR, ST_UPD_IR
   } tap_state_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jtag_in_t;

   typedef struct packed {
      logic tdo;
      logic tdo_oe_n;
   } jtag_out_t;

endpackage

// ### tap_shift.sv
// Capture/shift register of parameter width, LSB toward the output.
// Assumes the caller gives one-cycle capture and shift enables.
`timescale 1ns/1ps

module tap_shift #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic capture,
   input wire logic shift,
   input wire logic [WIDTH-1:0] capture_val,
   input wire logic shift_in,
   // Contents
   output logic [WIDTH-1:0] value
);
   if (WIDTH < 2) begin : g_bad_width
      $error("tap_shift: WIDTH must be at least 2");
   end

   // ----------------------------------------
   // Parallel capture, serial shift right
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         value <= '0;
      end else if (capture) begin
         value <= capture_val;
      end else if (shift) begin
         value <= {shift_in, value[WIDTH-1:1]};
      end
   end
endmodule

// ### tap_sync.sv
// Two-flop synchroniser for one bit per lane.
// Assumes inputs come from outside the clk domain.
`timescale 1ns/1ps

module tap_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Lanes
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_bad_width
      $error("tap_sync: WIDTH must be positive");
   end

   // ----------------------------------------
   // Synchroniser chain
   // ----------------------------------------
   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_q <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ### tb_sram_boundary_scan_tap.sv
// Self-checking bench of the boundary-scan port with a host model.
// Assumes tap_pkg and jtag_host are compiled first.
`timescale 1ns/1ps

module tb_sram_boundary_scan_tap;
   import tap_pkg::*;

   localparam int BSRW = 8;
   localparam int PINS = 6;
   localparam logic [31:0] ID_VAL = 32'h1234_5678; // Arbitrary value

   logic clk = 1'b0;
   logic nrst = 1'b0;
   jtag_in_t jin;
   jtag_out_t jout;
   logic tms_drv;
   logic tdi_drv;
   logic [PINS-1:0] ring = '0;
   logic mem_hiz;
   logic ext_on;
   logic [BSRW-1:0] bsr_upd;
   int failures = 0;
   int total_checks = 0;
   integer seed = 2;
   logic [2:0] notes[$]; // Care flag, enable, data

   // --------------------------------
   // Structure
   // --------------------------------
   sram_boundary_scan_tap #(.BSR_WIDTH(BSRW), .PIN_COUNT(PINS), .ID_CODE(ID_VAL)) i_dut (
      .clk(clk), .nrst(nrst), .jtag_in(jin), .tms_driven(tms_drv), .tdi_driven(tdi_drv),
      .jtag_out(jout), .ring_pins(ring), .mem_out_hiz(mem_hiz), .extest_on(ext_on),
      .bsr_update(bsr_upd));

   jtag_host i_host (.clk(clk), .pins(jin), .tms_driven(tms_drv), .tdi_driven(tdi_drv),
      .answer(jout));

   // 25 MHz system clock
   initial begin
      forever #20 clk = ~clk;
   end

   // --------------------------------
   // Checking
   // --------------------------------
   task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Oldest note against each answer the host reports
   initial begin
      logic [2:0] n;
      forever begin
         @(i_host.got);
         n = notes.pop_front();
         compare("tdo_oe_n", {31'h0, n[1]}, {31'h0, i_host.seen_oe_n});
         if (n[2]) compare("tdo", {31'h0, n[0]}, {31'h0, i_host.seen_tdo});
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Hang guard, well beyond the few thousand clk the tests need
   initial begin
      #(40 * 60000);
      failures++;
      give_verdict();
   end

   // --------------------------------
   // Stimulus
   // --------------------------------
   // Bit with no shift in flight: enable must stay high
   task automatic idle_bit(input logic tms);
      notes.push_back(3'b010);
      i_host.put_bit(tms, 1'b1);
   endtask

   // Idle to shift state, n bits, update, back to Idle
   task automatic scan(input bit ir, input int n, input logic [31:0] din,
                       input logic [31:0] exp, input logic [31:0] care);
      logic [3:0] head;
      head = ir ? 4'b0011 : 4'b0001;
      for (int i = 0; i < (ir ? 4 : 3); i++) idle_bit(head[i]);
      for (int i = 0; i < n; i++) begin
         notes.push_back({care[i], 1'b0, exp[i]});
         i_host.put_bit(i == n - 1, din[i]);
      end
      idle_bit(1'b1);
      idle_bit(1'b0);
   endtask

   initial begin
      logic [31:0] r;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      // Untouched port stays quiet
      repeat (20) @(negedge clk);
      compare("tdo_oe_n", 32'h1, {31'h0, jout.tdo_oe_n});
      compare("tdo", 32'h1, {31'h0, jout.tdo});
      compare("mem_out_hiz", 32'h0, {31'h0, mem_hiz});
      compare("extest_on", 32'h0, {31'h0, ext_on});
      $display("test quiet done");
      // Power-up instruction reads the identification value
      idle_bit(1'b0);
      scan(1'b0, 32, 32'h0, ID_VAL, 32'hffff_ffff);
      $display("test ident done");
      // Every instruction code in turn
      for (int c = 0; c < 8; c++) begin
         ring = PINS'($random(seed));
         r = $random(seed);
         scan(1'b1, 3, c, 32'h1, 32'h3);
         compare("mem_out_hiz", 32'(c == 2), {31'h0, mem_hiz});
         compare("extest_on", 32'(c == 0), {31'h0, ext_on});
         if (c == 1) scan(1'b0, 32, r, ID_VAL, 32'hffff_ffff);
         else if (c == 0 || c == 2 || c == 4) begin
            scan(1'b0, BSRW, r, {2'b11, ring}, 32'hff);
            compare("bsr_update", r[BSRW-1:0], bsr_upd);
         end
         else scan(1'b0, BSRW, r, {r[6:0], 1'b0}, 32'hff);
      end
      $display("test codes done");
      // Released data pin reads as one through bypass
      i_host.drive_tdi = 1'b0;
      scan(1'b0, BSRW, 32'h0, 32'hfe, 32'hff);
      i_host.drive_tdi = 1'b1;
      $display("test float data done");
      // Reset in mid-run drops a held hiz instruction and restores ident
      scan(1'b1, 3, 32'h2, 32'h1, 32'h3);
      compare("mem_out_hiz", 32'h1, {31'h0, mem_hiz});
      nrst = 1'b0;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      compare("mem_out_hiz", 32'h0, {31'h0, mem_hiz});
      compare("tdo", 32'h1, {31'h0, jout.tdo});
      idle_bit(1'b0);
      scan(1'b0, 32, 32'h0, ID_VAL, 32'hffff_ffff);
      scan(1'b1, 3, 32'h7, 32'h1, 32'h3);
      $display("test mid reset done");
      // five high mode bits, here from a released pin
      i_host.drive_tms = 1'b0;
      for (int i = 0; i < 5; i++) idle_bit(1'b0);
      i_host.drive_tms = 1'b1;
      idle_bit(1'b0);
      scan(1'b0, 32, 32'h0, ID_VAL, 32'hffff_ffff);
      $display("test mode reset done");
      give_verdict();
   end
endmodule
